// File: core/tx_ovh_pkg.sv
// Constants and types shared by the transmit alarm and test pattern logic
package tx_ovh_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_TX_ALARM_CONFIG = 8'h75;
  localparam logic [7:0] ADDR_TX_TEST_PATTERN_CONFIG = 8'h76;
  localparam logic [7:0] ADDR_TX_LOOP_CODE_CONFIG = 8'h77;

  // Values after reset
  localparam logic [6:0] ALARM_CONFIG_RESET = 7'h00;
  localparam logic [4:0] PATTERN_CONFIG_RESET = 5'h00;
  localparam logic [3:0] LOOP_CONFIG_RESET = 4'h0;
  localparam logic [7:0] READ_DATA_RESET = 8'h00;

  // Field positions
  localparam int ALARM_FIELD_MSB = 6;
  localparam int PATTERN_FIELD_MSB = 4;
  localparam int LOOP_FIELD_MSB = 3;

  // Pseudo random sequence lengths and feedback taps
  localparam int PRBS_STATE_WIDTH = 23;
  localparam logic [1:0] PRBS_SEL_11 = 2'h0;
  localparam logic [1:0] PRBS_SEL_15 = 2'h1;
  localparam logic [1:0] PRBS_SEL_20 = 2'h2;
  localparam logic [1:0] PRBS_SEL_23 = 2'h3;
  localparam int PRBS_LEN_11 = 11;
  localparam int PRBS_TAP_11 = 9;
  localparam int PRBS_LEN_15 = 15;
  localparam int PRBS_TAP_15 = 14;
  localparam int PRBS_LEN_20 = 20;
  localparam int PRBS_TAP_20 = 17;
  localparam int PRBS_LEN_23 = 23;
  localparam int PRBS_TAP_23 = 18;
  localparam logic [22:0] PRBS_SEED = 23'h7F_FFFF;

  // Zero run limits
  localparam logic [3:0] ZERO_LIMIT_SHORT = 4'h7;
  localparam logic [3:0] ZERO_LIMIT_LONG = 4'hE;
  localparam logic [3:0] ZERO_RUN_RESET = 4'h0;

  // Loop code lengths
  localparam logic [2:0] LOOP_CODE_MIN_LEN = 3'h4;
  localparam logic [2:0] LOOP_INDEX_RESET = 3'h0;

  typedef enum logic {
    CLK_LINE = 1'b0,
    CLK_ALT = 1'b1
  } clock_source_type;

  typedef struct packed {
    logic alt_clock_switch_en;
    logic auto_mf_remote_alarm_en;
    logic auto_remote_alarm_en;
    logic auto_all_ones_alarm_en;
    logic manual_mf_remote_alarm;
    logic manual_remote_alarm;
    logic manual_all_ones_alarm;
  } alarm_cfg_type;

  typedef struct packed {
    logic prbs_tx_start;
    logic framed;
    logic prbs_zero_run_limit_en;
    logic [1:0] prbs_length_select;
  } pattern_cfg_type;

  typedef struct packed {
    logic [1:0] loop_code_length;
    logic unframed;
    logic loop_code_tx_start;
  } loop_cfg_type;

  typedef struct packed {
    logic tx_clock_loss;
    logic rx_signal_loss;
    logic rx_frame_align_loss;
    logic rx_multiframe_align_loss;
  } status_type;

  // Everything the link side needs from the processor side
  typedef struct packed {
    logic ais;
    logic yel_insert;
    logic yel_value;
    logic myel_insert;
    logic myel_value;
    logic line_loopback_en;
    logic cas_framing_select;
    pattern_cfg_type pattern;
    loop_cfg_type loop;
    logic [6:0] loop_code_pattern;
  } link_ctrl_type;

  localparam link_ctrl_type LINK_CTRL_RESET = '0;

endpackage

// File: core/prbs_gen.sv
// Selectable length pseudo random generator with zero run limit
`timescale 1ns/1ns
module prbs_gen
  import tx_ovh_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic advance,
  input wire logic [1:0] length_select,
  input wire logic zero_limit_en,
  // Data
  output logic bit_out
);

  logic [PRBS_STATE_WIDTH-1:0] state;
  logic [3:0] zero_run;
  logic feedback;
  logic [3:0] zero_limit;
  logic invert;

  function automatic logic tap_bit(input logic [PRBS_STATE_WIDTH-1:0] s, input int len,
                                   input int tap);
    logic [PRBS_STATE_WIDTH-1:0] mask;
    mask = (PRBS_STATE_WIDTH'(1) << len) - PRBS_STATE_WIDTH'(1);
    if ((s & mask) == '0) begin
      tap_bit = 1'b1;
    end else begin
      tap_bit = s[len-1] ^ s[tap-1];
    end
  endfunction

  always_comb begin
    unique case (length_select)
      PRBS_SEL_11: feedback = tap_bit(state, PRBS_LEN_11, PRBS_TAP_11);
      PRBS_SEL_15: feedback = tap_bit(state, PRBS_LEN_15, PRBS_TAP_15);
      PRBS_SEL_20: feedback = tap_bit(state, PRBS_LEN_20, PRBS_TAP_20);
      PRBS_SEL_23: feedback = tap_bit(state, PRBS_LEN_23, PRBS_TAP_23);
    endcase
  end

  assign zero_limit = length_select[1] ? ZERO_LIMIT_LONG : ZERO_LIMIT_SHORT;
  assign invert = length_select[0] & ~zero_limit_en;

  always_comb begin
    if (zero_limit_en && zero_run >= zero_limit) begin
      bit_out = 1'b1;
    end else begin
      bit_out = feedback ^ invert;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= PRBS_SEED;
    end else if (advance) begin
      state <= {state[PRBS_STATE_WIDTH-2:0], feedback};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      zero_run <= ZERO_RUN_RESET;
    end else if (advance) begin
      zero_run <= bit_out ? ZERO_RUN_RESET : zero_run + 4'h1;
    end
  end

  a_zero_run_bound: assert property (@(posedge clk) disable iff (!rst_n)
    (zero_limit_en && advance) |-> (bit_out || zero_run < zero_limit))
    else $error("zero run exceeds limit");

  c_zero_limit_hit: cover property (@(posedge clk) disable iff (!rst_n)
    zero_limit_en && advance && zero_run == zero_limit);

endmodule // prbs_gen

// File: core/tx_alarm_test_pattern_insert.sv
// Transmit alarm formatting, clock switching, test pattern and loop code insertion
`timescale 1ns/1ns

// Function
// - Switch enabled and transmit clock lost: use alternate clock, send all-ones.
// - Switch enabled with manual all-ones: alternate clock and all-ones always.
// - Multiframe yellow: PCM when not inserted, else manual, auto-follow, or off.
// - Yellow: PCM when not inserted, else manual, auto-follow frame loss, or off.
// - All-ones replaces every line output, line loopback data included.
// - Automatic all-ones lasts while signal loss persists, never switches clock.
// - Framer loopback data is never altered by all-ones.
// - Auto plus switch: all-ones on either loss, alternate clock only on clock loss.
// - Two-bit selector picks sequence length 2^11, 2^15, 2^20 or 2^23.
// - 2^15 and 2^23 inverted unless zero limit; zero limit means never inverted.
// - Zero limit caps zero runs at 7 or 14 by length.
// - E1 framed mode skips slot 0, and slot 16 when CAS framing is chosen.
// - Unframed mode sends the sequence in every bit, framing included.
// - Loop code length field sends the first 4, 5, 6 or 7 pattern bits.
// - Overwrite option lets the loop code replace framing bits.
// - Start bit sends the loop code until it is cleared.
// - Loop code pattern starts at its top bit, bits 6 to 0.
module tx_alarm_test_pattern_insert
  import tx_ovh_pkg::*;
(
  // System clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // Processor register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_EN,
  input wire logic RD_EN,
  output logic [7:0] RD_DATA,
  // Settings held elsewhere in the framer
  input wire logic REMOTE_ALARM_INSERT_EN,
  input wire logic MF_REMOTE_ALARM_INSERT_EN,
  input wire logic CAS_FRAMING_SELECT,
  input wire logic LINE_LOOPBACK_EN,
  input wire logic [6:0] LOOP_CODE_PATTERN,
  // Status from monitors, asynchronous
  input wire logic TX_CLOCK_LOSS,
  input wire logic RX_SIGNAL_LOSS,
  input wire logic RX_FRAME_ALIGN_LOSS,
  input wire logic RX_MULTIFRAME_ALIGN_LOSS,
  // Clock source control
  output logic ALT_CLOCK_SELECT,
  // Transmit line clock domain
  input wire logic TX_LINK_CLK,
  input wire logic TX_PCM_INPUT,
  input wire logic RX_LOOP_DATA,
  input wire logic FRAME_BIT_POS,
  input wire logic TS16_POS,
  input wire logic YEL_BIT_POS,
  input wire logic MYEL_BIT_POS,
  output logic TX_NRZ_OUT,
  output logic TX_POSITIVE_RAIL_OUT,
  output logic TX_NEGATIVE_RAIL_OUT,
  output logic FRAMER_LOOP_DATA
);

  alarm_cfg_type alarm_cfg;
  pattern_cfg_type pattern_cfg;
  loop_cfg_type loop_cfg;
  status_type status_meta;
  status_type status_sync;
  status_type status_raw;
  logic ais_active;
  logic next_ais;
  clock_source_type next_clock_source;
  link_ctrl_type ctrl_sys;
  link_ctrl_type ctrl_meta;
  link_ctrl_type ctrl;
  logic link_rst_meta;
  logic link_rst_n;
  logic framing_pos;
  logic prbs_advance;
  logic prbs_bit;
  logic [2:0] loop_index;
  logic [2:0] loop_last;
  logic loop_slot;
  logic loop_bit;
  logic tx_bit;
  logic line_bit;
  logic next_nrz;
  logic mark_polarity;

  // Processor side: register writes
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      alarm_cfg <= ALARM_CONFIG_RESET;
      pattern_cfg <= PATTERN_CONFIG_RESET;
      loop_cfg <= LOOP_CONFIG_RESET;
    end else if (WR_EN) begin
      unique case (ADDR)
        ADDR_TX_ALARM_CONFIG: alarm_cfg <= WR_DATA[ALARM_FIELD_MSB:0];
        ADDR_TX_TEST_PATTERN_CONFIG: pattern_cfg <= WR_DATA[PATTERN_FIELD_MSB:0];
        ADDR_TX_LOOP_CODE_CONFIG: loop_cfg <= WR_DATA[LOOP_FIELD_MSB:0];
        default: ;
      endcase
    end
  end

  // Register reads; reserved bits and other addresses read zero
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      RD_DATA <= READ_DATA_RESET;
    end else if (RD_EN) begin
      unique case (ADDR)
        ADDR_TX_ALARM_CONFIG: RD_DATA <= {1'b0, alarm_cfg};
        ADDR_TX_TEST_PATTERN_CONFIG: RD_DATA <= {3'h0, pattern_cfg};
        ADDR_TX_LOOP_CODE_CONFIG: RD_DATA <= {4'h0, loop_cfg};
        default: RD_DATA <= READ_DATA_RESET;
      endcase
    end
  end

  // Status synchroniser
  assign status_raw = {TX_CLOCK_LOSS, RX_SIGNAL_LOSS, RX_FRAME_ALIGN_LOSS,
                       RX_MULTIFRAME_ALIGN_LOSS};

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      status_meta <= '0;
      status_sync <= '0;
    end else begin
      status_meta <= status_raw;
      status_sync <= status_meta;
    end
  end

  // All-ones and clock source decision
  always_comb begin
    next_ais = alarm_cfg.manual_all_ones_alarm
      | (alarm_cfg.auto_all_ones_alarm_en & status_sync.rx_signal_loss)
      | (alarm_cfg.alt_clock_switch_en & status_sync.tx_clock_loss);
    if (alarm_cfg.alt_clock_switch_en
        && (alarm_cfg.manual_all_ones_alarm || status_sync.tx_clock_loss)) begin
      next_clock_source = CLK_ALT;
    end else begin
      next_clock_source = CLK_LINE;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ais_active <= 1'b0;
      ALT_CLOCK_SELECT <= 1'b0;
    end else begin
      ais_active <= next_ais;
      ALT_CLOCK_SELECT <= (next_clock_source == CLK_ALT);
    end
  end

  // Control word for the link side
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ctrl_sys <= LINK_CTRL_RESET;
    end else begin
      ctrl_sys.ais <= next_ais;
      ctrl_sys.yel_insert <= REMOTE_ALARM_INSERT_EN;
      ctrl_sys.yel_value <= alarm_cfg.manual_remote_alarm
        | (alarm_cfg.auto_remote_alarm_en & status_sync.rx_frame_align_loss);
      ctrl_sys.myel_insert <= MF_REMOTE_ALARM_INSERT_EN;
      ctrl_sys.myel_value <= alarm_cfg.manual_mf_remote_alarm
        | (alarm_cfg.auto_mf_remote_alarm_en & status_sync.rx_multiframe_align_loss);
      ctrl_sys.line_loopback_en <= LINE_LOOPBACK_EN;
      ctrl_sys.cas_framing_select <= CAS_FRAMING_SELECT;
      ctrl_sys.pattern <= pattern_cfg;
      ctrl_sys.loop <= loop_cfg;
      ctrl_sys.loop_code_pattern <= LOOP_CODE_PATTERN;
    end
  end

  // Link side: reset and control crossing, all quasi-static levels
  always_ff @(posedge TX_LINK_CLK) begin
    link_rst_meta <= RST_N;
    link_rst_n <= link_rst_meta;
  end

  always_ff @(posedge TX_LINK_CLK) begin
    if (!link_rst_n) begin
      ctrl_meta <= LINK_CTRL_RESET;
      ctrl <= LINK_CTRL_RESET;
    end else begin
      ctrl_meta <= ctrl_sys;
      ctrl <= ctrl_meta;
    end
  end

  // Framing positions and pattern stepping
  assign framing_pos = FRAME_BIT_POS | (TS16_POS & ctrl.cas_framing_select);
  assign prbs_advance = ctrl.pattern.prbs_tx_start
    & ~(ctrl.pattern.framed & framing_pos);

  prbs_gen u_prbs (
    .clk(TX_LINK_CLK),
    .rst_n(link_rst_n),
    .advance(prbs_advance),
    .length_select(ctrl.pattern.prbs_length_select),
    .zero_limit_en(ctrl.pattern.prbs_zero_run_limit_en),
    .bit_out(prbs_bit)
  );

  // Loop code sequencer
  assign loop_last = LOOP_CODE_MIN_LEN + {1'b0, ctrl.loop.loop_code_length} - 3'h1;
  assign loop_slot = ctrl.loop.loop_code_tx_start
    & (ctrl.loop.unframed | ~FRAME_BIT_POS);
  assign loop_bit = ctrl.loop_code_pattern[3'h6 - loop_index];

  always_ff @(posedge TX_LINK_CLK) begin
    if (!link_rst_n || !ctrl.loop.loop_code_tx_start) begin
      loop_index <= LOOP_INDEX_RESET;
    end else if (loop_slot) begin
      loop_index <= (loop_index >= loop_last) ? LOOP_INDEX_RESET : loop_index + 3'h1;
    end
  end

  // Transmit bit selection
  always_comb begin
    tx_bit = TX_PCM_INPUT;
    if (YEL_BIT_POS && ctrl.yel_insert) begin
      tx_bit = ctrl.yel_value;
    end
    if (MYEL_BIT_POS && ctrl.myel_insert) begin
      tx_bit = ctrl.myel_value;
    end
    if (prbs_advance) begin
      tx_bit = prbs_bit;
    end
    if (loop_slot) begin
      tx_bit = loop_bit;
    end
    line_bit = ctrl.line_loopback_en ? RX_LOOP_DATA : tx_bit;
    next_nrz = ctrl.ais | line_bit;
  end

  // Line outputs with alternate mark encoding
  always_ff @(posedge TX_LINK_CLK) begin
    if (!link_rst_n) begin
      TX_NRZ_OUT <= 1'b0;
      TX_POSITIVE_RAIL_OUT <= 1'b0;
      TX_NEGATIVE_RAIL_OUT <= 1'b0;
      mark_polarity <= 1'b0;
    end else begin
      TX_NRZ_OUT <= next_nrz;
      TX_POSITIVE_RAIL_OUT <= next_nrz & ~mark_polarity;
      TX_NEGATIVE_RAIL_OUT <= next_nrz & mark_polarity;
      mark_polarity <= mark_polarity ^ next_nrz;
    end
  end

  // Framer loopback path ahead of all-ones
  always_ff @(posedge TX_LINK_CLK) begin
    if (!link_rst_n) begin
      FRAMER_LOOP_DATA <= 1'b0;
    end else begin
      FRAMER_LOOP_DATA <= tx_bit;
    end
  end

  // Processor side checks
  a_alt_on_loss: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (alarm_cfg.alt_clock_switch_en && status_sync.tx_clock_loss) |=> ALT_CLOCK_SELECT && ais_active)
    else $error("clock loss did not select alternate clock with all-ones");

  a_alt_manual: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (alarm_cfg.alt_clock_switch_en && alarm_cfg.manual_all_ones_alarm)
      |=> ALT_CLOCK_SELECT && ais_active)
    else $error("manual all-ones did not use alternate clock");

  a_auto_no_switch: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (alarm_cfg.auto_all_ones_alarm_en && status_sync.rx_signal_loss
      && !alarm_cfg.alt_clock_switch_en) |=> ais_active && !ALT_CLOCK_SELECT)
    else $error("signal loss all-ones wrong");

  a_alt_release: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (!alarm_cfg.manual_all_ones_alarm && !status_sync.tx_clock_loss) |=> !ALT_CLOCK_SELECT)
    else $error("alternate clock held without clock loss");

  a_yel_auto: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (alarm_cfg.auto_remote_alarm_en && status_sync.rx_frame_align_loss) |=> ctrl_sys.yel_value)
    else $error("yellow not following frame loss");

  a_myel_idle: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (!alarm_cfg.manual_mf_remote_alarm && !alarm_cfg.auto_mf_remote_alarm_en)
      |=> !ctrl_sys.myel_value)
    else $error("multiframe yellow active while off");

  // Link side checks
  a_ais_ones: assert property (@(posedge TX_LINK_CLK) disable iff (!link_rst_n)
    ctrl.ais |=> TX_NRZ_OUT && (TX_POSITIVE_RAIL_OUT != TX_NEGATIVE_RAIL_OUT))
    else $error("all-ones not sent");

  a_framer_loopback_en_clean: assert property (@(posedge TX_LINK_CLK) disable iff (!link_rst_n)
    (ctrl.ais && !loop_slot && !prbs_advance && !YEL_BIT_POS && !MYEL_BIT_POS)
      |=> FRAMER_LOOP_DATA == $past(TX_PCM_INPUT))
    else $error("framer loopback altered by all-ones");

  a_framed_hold: assert property (@(posedge TX_LINK_CLK) disable iff (!link_rst_n)
    (ctrl.pattern.framed && framing_pos) |-> !prbs_advance)
    else $error("sequence stepped over framing bit");

  a_unframed_all: assert property (@(posedge TX_LINK_CLK) disable iff (!link_rst_n)
    (ctrl.pattern.prbs_tx_start && !ctrl.pattern.framed) |-> prbs_advance)
    else $error("unframed sequence skipped a bit");

  a_loop_stop: assert property (@(posedge TX_LINK_CLK) disable iff (!link_rst_n)
    !ctrl.loop.loop_code_tx_start |=> loop_index == LOOP_INDEX_RESET)
    else $error("loop code index not cleared");

  a_loop_len: assert property (@(posedge TX_LINK_CLK) disable iff (!link_rst_n)
    (loop_slot && loop_index == loop_last && $stable(ctrl.loop))
      |=> loop_index == LOOP_INDEX_RESET)
    else $error("loop code length wrong");

  c_alt_clock: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
    $rose(ALT_CLOCK_SELECT));
  c_ais_line: cover property (@(posedge TX_LINK_CLK) disable iff (!link_rst_n)
    ctrl.ais ##1 TX_NRZ_OUT);
  c_loop_wrap: cover property (@(posedge TX_LINK_CLK) disable iff (!link_rst_n)
    loop_slot && loop_index == loop_last);
  c_prbs_run: cover property (@(posedge TX_LINK_CLK) disable iff (!link_rst_n)
    prbs_advance && loop_slot);

endmodule // tx_alarm_test_pattern_insert

// File: verif/line_far_end.sv
// Far-end line terminal model: line clock, frame positions, data and line code watch
`timescale 1ns/1ns
module line_far_end
  import tx_ovh_pkg::*;
#(
  parameter int FRAME_LEN = 193
) (
  // Line timing and data toward the transmitter
  output logic link_clk,
  output logic pcm_bit,
  output logic rx_bit,
  output logic frame_pos,
  output logic ts16_pos,
  output logic yel_pos,
  output logic myel_pos,
  // Line signal from the transmitter
  input wire logic pos_rail,
  input wire logic neg_rail,
  // Line code faults seen
  output int ami_faults
);
  int bit_cnt = 0;
  logic last_pos = 1'b0;

  // Line rate clock always present, so clock switching may be enabled
  initial begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end

  assign frame_pos = (bit_cnt == 0);
  // Yellow slot as the host's buffer setup places it
  assign yel_pos = (bit_cnt == 1);
  assign myel_pos = (bit_cnt == 2);
  assign ts16_pos = (bit_cnt >= 16) && (bit_cnt < 24);

  always @(negedge link_clk) begin
    bit_cnt <= (bit_cnt + 1) % FRAME_LEN;
    pcm_bit <= 1'($urandom);
    rx_bit <= 1'($urandom);
  end

  // Marks must alternate, positive first, never both rails
  always @(posedge link_clk) begin
    #1;
    if (pos_rail === 1'b1 && neg_rail === 1'b1) begin
      ami_faults++;
    end else if (pos_rail === 1'b1 || neg_rail === 1'b1) begin
      if (pos_rail === last_pos) begin
        ami_faults++;
      end
      last_pos = pos_rail;
    end
  end
endmodule // line_far_end

// File: verif/tx_alarm_test_pattern_insert_bench.sv
// Self-checking bench for alarms, clock switching, test pattern and loop code
`timescale 1ns/1ns
module tx_alarm_test_pattern_insert_bench
  import tx_ovh_pkg::*;
;
  logic CLK_SYS = 1'b0;
  logic RST_N = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [7:0] WR_DATA = 8'h00;
  logic WR_EN = 1'b0;
  logic RD_EN = 1'b0;
  logic REMOTE_ALARM_INSERT_EN = 1'b0;
  logic MF_REMOTE_ALARM_INSERT_EN = 1'b0;
  logic CAS_FRAMING_SELECT = 1'b0;
  logic LINE_LOOPBACK_EN = 1'b0;
  logic [6:0] LOOP_CODE_PATTERN = 7'h00;
  logic TX_CLOCK_LOSS = 1'b0;
  logic RX_SIGNAL_LOSS = 1'b0;
  logic RX_FRAME_ALIGN_LOSS = 1'b0;
  logic RX_MULTIFRAME_ALIGN_LOSS = 1'b0;
  logic [7:0] RD_DATA;
  logic ALT_CLOCK_SELECT, TX_LINK_CLK, TX_PCM_INPUT, RX_LOOP_DATA, FRAME_BIT_POS, TS16_POS;
  logic YEL_BIT_POS, MYEL_BIT_POS, TX_NRZ_OUT, TX_POSITIVE_RAIL_OUT, TX_NEGATIVE_RAIL_OUT;
  logic FRAMER_LOOP_DATA;
  int ami_faults;
  int errors = 0;
  int comparisons = 0;
  logic bits[$];
  logic [7:0] rdv;
  logic [7:0] masks[5] = '{8'h00, 8'h7F, 8'h1F, 8'h0F, 8'h00};
  int lens[4] = '{11, 15, 20, 23};
  int taps[4] = '{9, 14, 17, 18};

  always #2 CLK_SYS = ~CLK_SYS;

  tx_alarm_test_pattern_insert i_tx_alarm_test_pattern_insert (
    .CLK_SYS, .RST_N, .ADDR, .WR_DATA, .WR_EN, .RD_EN, .RD_DATA,
    .REMOTE_ALARM_INSERT_EN, .MF_REMOTE_ALARM_INSERT_EN, .CAS_FRAMING_SELECT,
    .LINE_LOOPBACK_EN, .LOOP_CODE_PATTERN, .TX_CLOCK_LOSS, .RX_SIGNAL_LOSS,
    .RX_FRAME_ALIGN_LOSS, .RX_MULTIFRAME_ALIGN_LOSS, .ALT_CLOCK_SELECT, .TX_LINK_CLK,
    .TX_PCM_INPUT, .RX_LOOP_DATA, .FRAME_BIT_POS, .TS16_POS, .YEL_BIT_POS, .MYEL_BIT_POS,
    .TX_NRZ_OUT, .TX_POSITIVE_RAIL_OUT, .TX_NEGATIVE_RAIL_OUT, .FRAMER_LOOP_DATA
  );

  line_far_end #(.FRAME_LEN(32)) i_line_far_end (
    .link_clk(TX_LINK_CLK), .pcm_bit(TX_PCM_INPUT), .rx_bit(RX_LOOP_DATA),
    .frame_pos(FRAME_BIT_POS), .ts16_pos(TS16_POS), .yel_pos(YEL_BIT_POS),
    .myel_pos(MYEL_BIT_POS), .pos_rail(TX_POSITIVE_RAIL_OUT),
    .neg_rail(TX_NEGATIVE_RAIL_OUT), .ami_faults(ami_faults)
  );

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLK_SYS);
    ADDR = a;
    WR_DATA = d;
    WR_EN = 1'b1;
    @(negedge CLK_SYS);
    WR_EN = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge CLK_SYS);
    ADDR = a;
    RD_EN = 1'b1;
    @(negedge CLK_SYS);
    RD_EN = 1'b0;
    @(negedge CLK_SYS);
    d = RD_DATA;
  endtask

  task automatic link_wait(input int n);
    repeat (n) @(posedge TX_LINK_CLK);
  endtask

  // Line bits against plain data with the given alarm overrides
  task automatic watch(input int n, input logic ais, input logic [1:0] ya, input logic [1:0] ma);
    logic t;
    logic line;
    repeat (n) begin
      @(posedge TX_LINK_CLK);
      t = (YEL_BIT_POS && ya[1]) ? ya[0] : TX_PCM_INPUT;
      t = (MYEL_BIT_POS && ma[1]) ? ma[0] : t;
      line = ais ? 1'b1 : (LINE_LOOPBACK_EN ? RX_LOOP_DATA : t);
      #1;
      check(8'(FRAMER_LOOP_DATA), 8'(t));
      check(8'(TX_NRZ_OUT), 8'(line));
      check(8'(TX_POSITIVE_RAIL_OUT | TX_NEGATIVE_RAIL_OUT), 8'(line));
    end
  endtask

  // Gathers inserted bits; kept positions must carry the plain data
  task automatic collect(input int n, input logic skip16, input logic keep);
    logic p;
    logic sk;
    bits.delete();
    repeat (n) begin
      @(posedge TX_LINK_CLK);
      p = TX_PCM_INPUT;
      sk = keep & (FRAME_BIT_POS | (skip16 & TS16_POS));
      #1;
      if (sk) check(8'(TX_NRZ_OUT), 8'(p));
      else bits.push_back(TX_NRZ_OUT);
    end
  endtask

  function automatic int prbs_faults(input int l, input int t, input logic inv);
    int f;
    f = 0;
    for (int k = l; k < bits.size(); k++) begin
      f += (bits[k] !== (bits[k - l] ^ bits[k - t] ^ inv));
    end
    return f;
  endfunction

  function automatic int max_zero_run();
    int run;
    int top;
    run = 0;
    top = 0;
    foreach (bits[k]) begin
      run = (bits[k] === 1'b0) ? run + 1 : 0;
      top = (run > top) ? run : top;
    end
    return top;
  endfunction

  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #350_000;
    errors++;
    $display("Watchdog expired at %0t", $time);
    summarize();
  end

  initial begin
    void'($urandom(19635));
    repeat (6) @(negedge CLK_SYS);
    repeat (4) @(posedge TX_LINK_CLK);
    @(negedge CLK_SYS);
    RST_N = 1'b1;
    link_wait(3);
    // Reset values, field read-back and unmapped places
    for (int r = 0; r < 5; r++) begin
      logic [7:0] a;
      logic [7:0] d;
      a = 8'h74 + 8'(r);
      d = 8'($urandom);
      if (masks[r] != 8'h00) d = d & masks[r];
      rd(a, rdv);
      check(rdv, 8'h00);
      wr(a, d);
      rd(a, rdv);
      check(rdv, d & masks[r]);
      wr(a, 8'h00);
    end
    $display("Test registers done");
    for (int i = 0; i < 32; i++) begin
      @(negedge CLK_SYS);
      {TX_CLOCK_LOSS, RX_SIGNAL_LOSS} = 2'(i);
      LINE_LOOPBACK_EN = 1'($urandom);
      wr(ADDR_TX_ALARM_CONFIG, {1'b0, i[2], 2'b00, i[3], 2'b00, i[4]});
      link_wait(6);
      check(8'(ALT_CLOCK_SELECT), 8'(i[2] & (i[4] | i[1])));
      watch(8, i[4] | (i[3] & i[0]) | (i[2] & i[1]), 2'b00, 2'b00);
    end
    $display("Test all-ones and clock switch done");
    for (int i = 0; i < 16; i++) begin
      logic [3:0] y;
      logic [3:0] m;
      y = 4'(i);
      m = y ^ 4'b0101;
      @(negedge CLK_SYS);
      {LINE_LOOPBACK_EN, TX_CLOCK_LOSS, RX_SIGNAL_LOSS} = 3'b000;
      {REMOTE_ALARM_INSERT_EN, RX_FRAME_ALIGN_LOSS} = {y[0], y[3]};
      {MF_REMOTE_ALARM_INSERT_EN, RX_MULTIFRAME_ALIGN_LOSS} = {m[0], m[3]};
      wr(ADDR_TX_ALARM_CONFIG, {2'b00, m[2], y[2], 1'b0, m[1], y[1], 1'b0});
      link_wait(6);
      watch(34, 1'b0, {y[0], y[1] | (y[2] & y[3])}, {m[0], m[1] | (m[2] & m[3])});
    end
    @(negedge CLK_SYS);
    {REMOTE_ALARM_INSERT_EN, MF_REMOTE_ALARM_INSERT_EN} = 2'b00;
    wr(ADDR_TX_ALARM_CONFIG, 8'h00);
    $display("Test remote alarms done");
    for (int i = 0; i < 16; i++) begin
      @(negedge CLK_SYS);
      CAS_FRAMING_SELECT = i[3] & 1'($urandom);
      wr(ADDR_TX_TEST_PATTERN_CONFIG, {4'h1, i[3], i[2], i[1:0]});
      link_wait(6);
      collect(400, CAS_FRAMING_SELECT, i[3]);
      if (i[2]) begin
        check(8'(max_zero_run() > (i[1] ? 14 : 7)), 8'h00);
        check(8'(prbs_faults(lens[i[1:0]], taps[i[1:0]], 1'b0) * 4 > 400), 8'h00);
      end else begin
        check(8'(prbs_faults(lens[i[1:0]], taps[i[1:0]], i[0]) != 0), 8'h00);
      end
    end
    wr(ADDR_TX_TEST_PATTERN_CONFIG, 8'h00);
    CAS_FRAMING_SELECT = 1'b0;
    $display("Test pattern generator done");
    // Loop code wins over a running framed sequence, with and without overwrite
    for (int i = 0; i < 8; i++) begin
      int len;
      int best;
      @(negedge CLK_SYS);
      LOOP_CODE_PATTERN = 7'($urandom);
      len = 4 + i[2:1];
      wr(ADDR_TX_TEST_PATTERN_CONFIG, 8'h18);
      wr(ADDR_TX_LOOP_CODE_CONFIG, {4'h0, i[2:1], i[0], 1'b1});
      link_wait(6);
      collect(70, 1'b0, !i[0]);
      best = 99;
      for (int o = 0; o < len; o++) begin
        int f;
        f = 0;
        foreach (bits[k]) f += (bits[k] !== LOOP_CODE_PATTERN[6 - ((k + o) % len)]);
        best = (f < best) ? f : best;
      end
      check(8'(best != 0), 8'h00);
      wr(ADDR_TX_LOOP_CODE_CONFIG, 8'h00);
      wr(ADDR_TX_TEST_PATTERN_CONFIG, 8'h00);
      link_wait(6);
      watch(8, 1'b0, 2'b00, 2'b00);
    end
    $display("Test loop code done");
    check(8'(ami_faults != 0), 8'h00);
    summarize();
  end
endmodule // tx_alarm_test_pattern_insert_bench
